// ---- rtl/sfs_pkg.sv ----
/*
  Constants for the sample FIFO status and interrupt routing block.
  Assumes byte-wide registers at their printed eight-bit addresses.
*/
package sfs_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_STATUS     = 8'h11;  // Event status, read only
  localparam logic [7:0] ADDR_FIFO_DATA  = 8'h1d;  // Sample read port, no auto-increment
  localparam logic [7:0] ADDR_MAP_A      = 8'h2b;  // Pin A routing
  localparam logic [7:0] ADDR_MAP_A_HI   = 8'h2c;  // Pin polarity
  localparam logic [7:0] ADDR_MAP_B_LO   = 8'h2d;  // Spare routing byte
  localparam logic [7:0] ADDR_MAP_B      = 8'h2e;  // Pin B routing
  localparam logic [7:0] ADDR_SETUP_LOW  = 8'h30;  // Mode, trigger source, threshold msb
  localparam logic [7:0] ADDR_THRESHOLD  = 8'h31;  // Threshold low byte

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_FULL      = 1;
  localparam int BIT_OVERRUN   = 2;
  localparam int BIT_WATERMARK = 3;
  localparam int BIT_READY     = 4;
  localparam int BIT_THR_MSB   = 0;
  localparam int BIT_EXT_TRIG  = 3;
  localparam int BIT_MODE_LO   = 4;
  localparam int BIT_MODE_HI   = 5;
  localparam int BIT_POL_A     = 0;
  localparam int BIT_POL_B     = 1;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int          DEPTH      = 320;    // Storage words
  localparam int          CNT_W      = 9;      // Sample count width
  localparam logic [8:0]  CAP_FULL   = 9'h140; // 320 samples
  localparam logic [8:0]  CAP_THREE  = 9'h13e; // 318 samples, three channels
  localparam logic [2:0]  THREE_CH   = 3'h3;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [8:0]  CNT_ZERO   = 9'h000;
  localparam logic [8:0]  CNT_ONE    = 9'h001;

  // FIFO operating mode field
  typedef enum logic [1:0] {
    SFS_MODE_OFF     = 2'h0,
    SFS_MODE_NORMAL  = 2'h1,
    SFS_MODE_STREAM  = 2'h2,
    SFS_MODE_TRIGGER = 2'h3
  } sfs_mode_e;

  // Trigger capture sequence
  typedef enum logic [2:0] {
    SFS_TRG_WAIT = 3'b001,
    SFS_TRG_POST = 3'b010,
    SFS_TRG_HELD = 3'b100
  } sfs_trg_e;
endpackage

// ---- rtl/sfs_fifo_if.sv ----
/*
  Signals between the status logic and the sample storage core.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface sfs_fifo_if;
  import sfs_pkg::*;
  logic             push;       // Store one sample
  logic             overwrite;  // Drop oldest when full
  logic [15:0]      push_data;  // Sample to store
  logic             pop;        // Release the oldest sample
  logic             flush;      // Empty the store
  logic [CNT_W-1:0] capacity;   // Current usable depth
  logic [CNT_W-1:0] count;      // Samples held
  logic [15:0]      head_data;  // Oldest sample

  modport ctrl (output push, overwrite, push_data, pop, flush, capacity,
                input count, head_data);
  modport core (input push, overwrite, push_data, pop, flush, capacity,
                output count, head_data);
endinterface

// ---- rtl/sfs_sample_store.sv ----
/*
  Sample storage core: circular array with read and write pointers.
  Assumes the controller never pops when empty.
*/
`timescale 1ns/1ps
module sfs_sample_store
  import sfs_pkg::*;
#(
  parameter int WORDS = DEPTH
)(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Controller side
  sfs_fifo_if.core  fifo
);
  // ****************************************
  // Storage
  // ****************************************
  logic [15:0]      mem [WORDS];  // Sample array
  logic [CNT_W-1:0] wr_ptr;       // Next write slot
  logic [CNT_W-1:0] rd_ptr;       // Oldest slot
  logic [CNT_W-1:0] count;        // Samples held
  logic             full;         // At usable depth
  logic             do_pop;       // Pointer advance on read side

  // Pointer step with wrap at the array end
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] p);
    step = (p == CNT_W'(WORDS - 1)) ? CNT_ZERO : p + CNT_ONE;
  endfunction

  assign full   = (count >= fifo.capacity);
  // Overwrite of a full store drops the oldest entry
  assign do_pop = fifo.pop || (fifo.push && full && fifo.overwrite);

  // Array write; data only, no reset needed
  always_ff @(posedge core_clk)
  begin
    if (fifo.push && (!full || fifo.overwrite))
    begin
      mem[wr_ptr] <= fifo.push_data;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk)
  begin
    if (!resetn || fifo.flush)
    begin
      wr_ptr <= CNT_ZERO;
      rd_ptr <= CNT_ZERO;
      count  <= CNT_ZERO;
    end
    else
    begin
      if (fifo.push && (!full || fifo.overwrite))
      begin
        wr_ptr <= step(wr_ptr);
      end
      if (do_pop)
      begin
        rd_ptr <= step(rd_ptr);
      end
      // Count moves only when exactly one side acts
      if (fifo.push && !full && !fifo.pop)
      begin
        count <= count + CNT_ONE;
      end
      else if (fifo.pop && !fifo.push)
      begin
        count <= count - CNT_ONE;
      end
    end
  end

  assign fifo.count     = count;
  assign fifo.head_data = mem[rd_ptr];
endmodule

// ---- rtl/sfs_fifo_status.sv ----
/*
  FIFO status flags, drain port and interrupt routing of the sample FIFO.
  Assumes a byte register port driven by the serial front end in this clock,
  one sample_valid pulse per new sample, and synchronous trigger inputs.
*/
`timescale 1ns/1ps
module sfs_fifo_status
  import sfs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  input  wire logic       reg_rd_first,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Sample source
  input  wire logic       sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic [3:0] channel_enable,
  // Trigger sources
  input  wire logic       activity_event,
  input  wire logic       external_event,
  // Interrupt pins
  output logic            interrupt_pin_a,
  output logic            interrupt_pin_b
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]  map_a;          // Pin A routing
  logic [7:0]  map_a_hi;       // Pin polarity
  logic [7:0]  map_b_lo;       // Spare routing byte
  logic [7:0]  map_b;          // Pin B routing
  logic [7:0]  setup_low;      // Mode and threshold msb
  logic [7:0]  thr_low;        // Threshold low byte
  logic        flag_full;      // Status flags
  logic        flag_overrun;
  logic        flag_wm;
  logic        flag_ready;
  logic [7:0]  auto_addr;      // Burst read address
  logic        low_byte;       // Next read of data port gives low byte
  sfs_trg_e    trg_state;      // Trigger capture sequence
  logic [8:0]  post_cnt;       // Samples taken after trigger

  // ****************************************
  // Decoded controls
  // ****************************************
  sfs_mode_e   mode;
  logic [8:0]  threshold;
  logic [8:0]  capacity;
  logic        is_full;
  logic        trig_in;
  logic        accept;         // Sample goes into the store
  logic        lost;           // Sample overwrote unread data in trigger mode or was dropped in normal mode
  logic [7:0]  rd_addr;
  logic        data_rd;
  logic        pop_now;
  logic [7:0]  status_byte;
  logic [7:0]  next_rdata;

  sfs_fifo_if fifo ();

  // Number of enabled channels
  function automatic logic [2:0] ones(input logic [3:0] v);
    ones = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  assign mode      = sfs_mode_e'(setup_low[BIT_MODE_HI:BIT_MODE_LO]);
  assign threshold = {setup_low[BIT_THR_MSB], thr_low};
  // A three-channel set fits 106 whole sets in 318 words
  assign capacity  = (ones(channel_enable) == THREE_CH) ? CAP_THREE : CAP_FULL;
  assign is_full   = (fifo.count >= capacity);
  assign trig_in   = setup_low[BIT_EXT_TRIG] ? external_event : activity_event;

  // Storing policy per mode
  always_comb
  begin
    accept = 1'b0;
    lost   = 1'b0;
    case (mode)
      SFS_MODE_NORMAL:
      begin
        accept = sample_valid && !is_full;
        lost   = sample_valid && is_full;
      end
      SFS_MODE_STREAM:
      begin
        accept = sample_valid;               // Overwrite is by design here
      end
      SFS_MODE_TRIGGER:
      begin
        // Capture stops once threshold samples have followed the event
        accept = sample_valid && (trg_state != SFS_TRG_HELD)
                 && !((trg_state == SFS_TRG_POST) && (post_cnt >= threshold));
        lost   = accept && is_full;
      end
      default:
      begin
        accept = 1'b0;                       // Disabled stores nothing
      end
    endcase
  end

  // Burst address: start address on the first byte, then the auto pointer
  assign rd_addr = reg_rd_first ? reg_addr : auto_addr;
  assign data_rd = reg_rd && (rd_addr == ADDR_FIFO_DATA);
  assign pop_now = data_rd && low_byte && (fifo.count != CNT_ZERO)
                   && (mode != SFS_MODE_OFF);

  assign fifo.push      = accept;
  assign fifo.overwrite = (mode != SFS_MODE_NORMAL);
  assign fifo.push_data = sample_data;
  assign fifo.pop       = pop_now;
  assign fifo.flush     = (mode == SFS_MODE_OFF);
  assign fifo.capacity  = capacity;

  sfs_sample_store #(
    .WORDS (DEPTH)
  ) u_store (
    .core_clk (core_clk),
    .resetn   (resetn),
    .fifo     (fifo.core)
  );

  // ****************************************
  // Register writes
  // ****************************************
  // Writable configuration bytes
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      map_a     <= REG_RESET;
      map_a_hi  <= REG_RESET;
      map_b_lo  <= REG_RESET;
      map_b     <= REG_RESET;
      setup_low <= REG_RESET;
      thr_low   <= REG_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_MAP_A:     map_a     <= reg_wdata;
        ADDR_MAP_A_HI:  map_a_hi  <= reg_wdata;
        ADDR_MAP_B_LO:  map_b_lo  <= reg_wdata;
        ADDR_MAP_B:     map_b     <= reg_wdata;
        ADDR_SETUP_LOW: setup_low <= reg_wdata;
        ADDR_THRESHOLD: thr_low   <= reg_wdata;
        default:        ;                        // Read-only or unmapped
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Address walk; sticks at the data port so bursts keep draining
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      auto_addr <= REG_RESET;
      low_byte  <= 1'b0;
    end
    else if (reg_rd)
    begin
      auto_addr <= (rd_addr == ADDR_FIFO_DATA) ? rd_addr : rd_addr + 8'h01;
      // High byte first, low byte second; a new burst restarts the pair
      low_byte  <= data_rd ? !(low_byte && !reg_rd_first) : 1'b0;
    end
  end

  assign status_byte = {3'h0, flag_ready, flag_wm, flag_overrun, flag_full, 1'b0};

  // Read data mux
  always_comb
  begin
    case (rd_addr)
      ADDR_STATUS:    next_rdata = status_byte;
      ADDR_FIFO_DATA:
      begin
        if ((mode == SFS_MODE_OFF) || (fifo.count == CNT_ZERO))
        begin
          next_rdata = REG_RESET;  // Disabled or empty reads zero
        end
        else
        begin
          next_rdata = (low_byte && !reg_rd_first) ? fifo.head_data[7:0]
                                                   : fifo.head_data[15:8];
        end
      end
      ADDR_MAP_A:     next_rdata = map_a;
      ADDR_MAP_A_HI:  next_rdata = map_a_hi;
      ADDR_MAP_B_LO:  next_rdata = map_b_lo;
      ADDR_MAP_B:     next_rdata = map_b;
      ADDR_SETUP_LOW: next_rdata = setup_low;
      ADDR_THRESHOLD: next_rdata = thr_low;
      default:        next_rdata = REG_RESET;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      reg_rdata  <= REG_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ****************************************
  // Trigger capture
  // ****************************************
  // Waits for the event, then takes threshold samples and freezes
  always_ff @(posedge core_clk)
  begin
    if (!resetn || (mode != SFS_MODE_TRIGGER))
    begin
      trg_state <= SFS_TRG_WAIT;
      post_cnt  <= CNT_ZERO;
    end
    else
    begin
      case (trg_state)
        SFS_TRG_WAIT:
        begin
          if (trig_in)
          begin
            trg_state <= SFS_TRG_POST;
          end
        end
        SFS_TRG_POST:
        begin
          if (post_cnt >= threshold)
          begin
            trg_state <= SFS_TRG_HELD;
          end
          else if (sample_valid)
          begin
            post_cnt <= post_cnt + CNT_ONE;
          end
        end
        SFS_TRG_HELD: trg_state <= SFS_TRG_HELD;  // Held until mode changes
        default:      trg_state <= SFS_TRG_WAIT;
      endcase
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Level flags follow the live count one cycle late
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      flag_wm    <= 1'b0;
      flag_ready <= 1'b0;
      flag_full  <= 1'b0;
    end
    else
    begin
      flag_wm    <= (fifo.count >= threshold) && (mode != SFS_MODE_OFF);
      flag_ready <= (fifo.count != CNT_ZERO) && (mode != SFS_MODE_OFF);
      flag_full  <= is_full && (mode != SFS_MODE_OFF);
    end
  end

  // Sticky overrun; a loss in the same cycle as a clear keeps the flag
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      flag_overrun <= 1'b0;
    end
    else if (lost)
    begin
      flag_overrun <= 1'b1;
    end
    else if (pop_now || (mode == SFS_MODE_OFF) || (mode == SFS_MODE_STREAM))
    begin
      flag_overrun <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt pins
  // ****************************************
  // Watermark reaches a pin only in normal or stream mode
  logic [7:0] irq_src;
  assign irq_src = {status_byte[7:BIT_WATERMARK+1],
                    flag_wm && ((mode == SFS_MODE_NORMAL) || (mode == SFS_MODE_STREAM)),
                    status_byte[BIT_WATERMARK-1:0]};

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      interrupt_pin_a <= 1'b0;
      interrupt_pin_b <= 1'b0;
    end
    else
    begin
      interrupt_pin_a <= (|(irq_src & map_a)) ^ map_a_hi[BIT_POL_A];
      interrupt_pin_b <= (|(irq_src & map_b)) ^ map_a_hi[BIT_POL_B];
    end
  end
endmodule

// ---- tb/sfs_fifo_status_sva.sv ----
/*
  Port checker for the FIFO status block.
  Assumes a bind onto the top module; sees its ports only.
*/
`timescale 1ns/1ps
module sfs_fifo_status_sva
  import sfs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  input  wire logic       reg_rd_first,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  // Samples and pins
  input  wire logic       sample_valid,
  input  wire logic       interrupt_pin_a,
  input  wire logic       interrupt_pin_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Shadow state
  // ****************************************
  logic [7:0] map_a;    // Pin A routing copy
  logic [7:0] map_b;    // Pin B routing copy
  logic [7:0] pol;      // Polarity copy
  logic [1:0] mode;     // FIFO mode copy
  logic [1:0] quiet;    // Edges since last write
  logic       settled;  // Pins reflect the shadows
  // Copy register writes so pin checks know the routing
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      map_a <= REG_RESET;
      map_b <= REG_RESET;
      pol   <= REG_RESET;
      mode  <= 2'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_MAP_A:     map_a <= reg_wdata;
        ADDR_MAP_B:     map_b <= reg_wdata;
        ADDR_MAP_A_HI:  pol   <= reg_wdata;
        ADDR_SETUP_LOW: mode  <= reg_wdata[BIT_MODE_HI:BIT_MODE_LO];
        default:        ;
      endcase
    end
  end
  // Pins lag a write by two edges, so checks wait for three
  always_ff @(posedge core_clk)
  begin
    if (!resetn || reg_wr)
      quiet <= 2'h0;
    else if (quiet != 2'h3)
      quiet <= quiet + 2'h1;
  end
  assign settled = quiet == 2'h3;
  // ****************************************
  // Assertions
  // ****************************************
  rvalid_follows_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  rvalid_only_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("rvalid without read strobe");
  rdata_holds_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved between reads");
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn |=> !reg_rvalid && reg_rdata == 8'h00 && !interrupt_pin_a && !interrupt_pin_b)
    else $error("outputs not cleared by reset");
  unmapped_zero_a: assert property (reg_rd && reg_rd_first && reg_addr == 8'h00
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  off_reads_zero_a: assert property (settled && mode == 2'h0 && reg_rd
    && reg_rd_first && reg_addr == ADDR_FIFO_DATA |=> reg_rdata == 8'h00)
    else $error("disabled FIFO read not zero");
  pin_idle_a: assert property ((settled && map_a == 8'h00
    && !pol[BIT_POL_A])[*2] |-> !interrupt_pin_a)
    else $error("unmapped pin A active");
  pin_b_idle_a: assert property (settled && map_b == 8'h00
    && !pol[BIT_POL_B] |-> !interrupt_pin_b)
    else $error("unmapped pin B active");
  pol_invert_a: assert property (settled && map_a == 8'h00
    && pol[BIT_POL_A] |-> interrupt_pin_a)
    else $error("inverted idle pin A low");
  ready_pin_a: assert property (sample_valid && settled && !reg_rd
    && (mode == 2'h1 || mode == 2'h2) && map_a[BIT_READY] && !pol[BIT_POL_A]
    ##1 (!reg_rd && !reg_wr)[*2] |=> interrupt_pin_a)
    else $error("sample did not raise pin A");
  // Main scenarios reached
  cover property (sample_valid && interrupt_pin_a);
  cover property (reg_rvalid && reg_rdata != 8'h00);
  cover property (interrupt_pin_b && mode == 2'h2);
endmodule

// ---- tb/sfs_host_model.sv ----
/*
  Host processor model: byte reads and writes on the register port.
  Assumes callers enter at a falling edge.
*/
`timescale 1ns/1ps
module sfs_host_model
  import sfs_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            reg_rd_first,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    reg_rd_first = 1'b0;
  end
  // Strobes stay up at return so back-to-back calls never toggle twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_rd = 1'b0;
    reg_rd_first = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // One byte; without first the device continues the burst from its own address
  task automatic rd(input logic [7:0] a, input logic f, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_wr = 1'b0;
    reg_rd_first = f;
    reg_addr = a;
    @(posedge core_clk);
    @(negedge core_clk);
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
  // Stall for n cycles with the port quiet
  task automatic idle(input int n);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask
endmodule

// ---- tb/sfs_fifo_status_test.sv ----
/*
  Self-checking bench for the FIFO status block.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
module sfs_fifo_status_test;
  import sfs_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        core_clk, resetn, reg_wr, reg_rd, reg_rd_first, reg_rvalid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, b;
  logic        sample_valid, interrupt_pin_a, interrupt_pin_b;
  logic        activity_event, external_event;  // Trigger sources
  logic [15:0] sample_data, seq;
  logic [3:0]  channel_enable;
  logic [1:0]  md;          // Mode in force
  logic [15:0] q[$];        // Expected FIFO contents
  int          cap, miscompares, comparisons;
  sfs_fifo_status sfs_fifo_status_i (.core_clk, .resetn, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rd_first, .reg_rdata, .reg_rvalid, .sample_valid,
    .sample_data, .channel_enable, .activity_event, .external_event,
    .interrupt_pin_a, .interrupt_pin_b);
  sfs_host_model sfs_host_model_i (.core_clk, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rd_first, .reg_rdata, .reg_rvalid);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic status(input logic [7:0] e);
    sfs_host_model_i.rd(ADDR_STATUS, 1'b1, b);
    sfs_host_model_i.idle(1);
    chk("status", e, b & 8'h1e);
  endtask
  task automatic pins(input logic a, input logic p);
    chk("pins", {a, p}, {interrupt_pin_a, interrupt_pin_b});
  endtask
  task automatic mode(input logic [1:0] m);
    md = m;
    q.delete();
    sfs_host_model_i.wr(ADDR_SETUP_LOW, {2'h0, m, 4'h0});
    sfs_host_model_i.idle(3);
  endtask
  // Normal mode drops when full, the others drop the oldest
  task automatic push(input int n);
    repeat (n)
    begin
      sample_valid = 1'b1;
      sample_data = seq;
      if (md != SFS_MODE_NORMAL && q.size() == cap)
        void'(q.pop_front());
      if (q.size() < cap)
        q.push_back(seq);
      seq++;
      @(negedge core_clk);
    end
    sample_valid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic drain(input int n, input logic f);
    for (int i = 0; i < n; i++)
    begin
      sfs_host_model_i.rd(ADDR_FIFO_DATA, f && i == 0, b);
      chk("high byte", q[0][15:8], b);
      sfs_host_model_i.rd(ADDR_FIFO_DATA, 1'b0, b);
      chk("low byte", q.pop_front() & 16'h00ff, b);
    end
    sfs_host_model_i.idle(3);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] a[6] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h31, 8'h30};
    foreach (a[i]) sfs_host_model_i.wr(a[i], 8'h09 + 8'h0c * i[7:0]);
    foreach (a[i])
    begin
      sfs_host_model_i.rd(a[i], 1'b1, b);
      chk("reg", 8'h09 + 8'h0c * i[7:0], b);
    end
    sfs_host_model_i.rd(8'h00, 1'b1, b);
    chk("unmapped", 8'h00, b);
    sfs_host_model_i.wr(ADDR_STATUS, 8'hff);
    sfs_host_model_i.wr(ADDR_MAP_A_HI, 8'h03);
    sfs_host_model_i.idle(3);
    status(8'h00);
    pins(1'b1, 1'b1);
  endtask
  task automatic t_normal;
    sfs_host_model_i.wr(ADDR_MAP_A_HI, 8'h00);
    sfs_host_model_i.wr(ADDR_THRESHOLD, 8'h04);
    sfs_host_model_i.wr(ADDR_MAP_A, 8'h10);
    sfs_host_model_i.wr(ADDR_MAP_B, 8'h08);
    mode(SFS_MODE_NORMAL);
    push(3);
    status(8'h10);
    pins(1'b1, 1'b0);
    push(1);
    status(8'h18);
    pins(1'b1, 1'b1);
    push(316);
    status(8'h1a);
    push(1);
    status(8'h1e);
    sfs_host_model_i.rd(8'h1c, 1'b1, b);
    chk("gap", 8'h00, b);
    drain(2, 1'b0);
    status(8'h18);
    push(1);
    drain(q.size() - 4, 1'b1);
    status(8'h18);
    drain(1, 1'b1);
    status(8'h10);
    drain(3, 1'b1);
    status(8'h00);
    pins(1'b0, 1'b0);
  endtask
  task automatic t_modes;
    channel_enable = 4'h7;
    cap = 318;
    mode(SFS_MODE_NORMAL);
    push(317);
    status(8'h18);
    push(2);
    status(8'h1e);
    mode(SFS_MODE_OFF);
    status(8'h00);
    sfs_host_model_i.rd(ADDR_FIFO_DATA, 1'b1, b);
    chk("off read", 8'h00, b);
    mode(SFS_MODE_STREAM);
    push(320);
    status(8'h1a);
    pins(1'b1, 1'b1);
    drain(1, 1'b1);
    mode(SFS_MODE_OFF);
    mode(SFS_MODE_TRIGGER);
    push(5);
    status(8'h18);
    pins(1'b1, 1'b0);
    // Event, then exactly threshold (4) samples are kept
    activity_event = 1'b1;
    @(negedge core_clk);
    activity_event = 1'b0;
    push(4);
    // Capture is held: further samples must be dropped
    md = SFS_MODE_NORMAL;
    cap = q.size();
    push(3);
    md = SFS_MODE_TRIGGER;
    cap = 318;
    drain(9, 1'b1);
    status(8'h00);
    mode(SFS_MODE_OFF);
  endtask
  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    resetn = 1'b0;
    sample_valid = 1'b0;
    activity_event = 1'b0;
    external_event = 1'b0;
    sample_data = 16'h0000;
    channel_enable = 4'hf;
    seq = 16'h1000;
    md = SFS_MODE_OFF;
    cap = 320;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    t_regs();
    t_normal();
    t_modes();
    tally_and_finish();
  end
endmodule
bind sfs_fifo_status sfs_fifo_status_sva sfs_fifo_status_sva_i (.core_clk, .resetn,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rd_first, .reg_rdata, .reg_rvalid,
  .sample_valid, .interrupt_pin_a, .interrupt_pin_b);
